// [rtl/pcsa_core.sv]
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
module pcsa_core
  import pcsa_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] fileAddr,
  input wire logic fileWrite,
  output logic [12:0] progAddr,
  output logic [8:0] dataAddr,
  output logic dataWriteEn,
  output logic dataReadZero
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [12:0] pc_reg;
  logic [7:0] pc_high_latch_reg;
  logic [7:0] file_select_pointer_reg;
  logic [7:0] status_reg;
  logic [31:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic awHeld_reg;
  logic wHeld_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [1:0] bresp_reg;
  pcsa_bus_e bus_reg;
  logic [12:0] stackTop;
  logic [8:0] effAddr;
  logic selfRef;

  // ----------------------------------------
  // Bus write acceptance
  // ----------------------------------------
  logic wrFire;
  logic [7:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic wrOk;
  logic [2:0] ctrlOp;
  logic [12:0] ctrlArg;

  assign s_axi_awready = (bus_reg == ST_IDLE) && !awHeld_reg;
  assign s_axi_wready = (bus_reg == ST_IDLE) && !wHeld_reg;
  assign wrAddr = awHeld_reg ? awaddr_reg[7:0] : s_axi_awaddr;
  assign wrData = wHeld_reg ? wdata_reg : s_axi_wdata;
  assign wrStrb = wHeld_reg ? wstrb_reg : s_axi_wstrb;
  // Write fires once both halves are present, in either order
  assign wrFire = (bus_reg == ST_IDLE) && (awHeld_reg || s_axi_awvalid) && (wHeld_reg || s_axi_wvalid);
  assign ctrlOp = wrData[CTRL_OP_LSB +: CTRL_OP_WIDTH];
  assign ctrlArg = wrData[CTRL_ARG_WIDTH-1:0];

  always_comb begin
    case (wrAddr)
      ADDR_PC_LOW, ADDR_HIGH_LATCH, ADDR_POINTER, ADDR_STATUS,
      ADDR_CONTROL, ADDR_IND_DATA: wrOk = 1'b1;
      default: wrOk = 1'b0;
    endcase
  end

  // Half-captured write channels wait for their partner
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else if (wrFire) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_reg <= 1'b1;
        awaddr_reg <= {24'h000000, s_axi_awaddr};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
    end
  end

  // ----------------------------------------
  // Program counter sequencing
  // ----------------------------------------
  logic wrPcLow;
  logic doCall;
  logic doJump;
  logic doRet;
  logic doIrq;
  logic doStep;

  assign wrPcLow = wrFire && (wrAddr == ADDR_PC_LOW) && wrStrb[0];
  assign doCall = wrFire && (wrAddr == ADDR_CONTROL) && (ctrlOp == OP_CALL);
  assign doJump = wrFire && (wrAddr == ADDR_CONTROL) && (ctrlOp == OP_JUMP);
  assign doRet = wrFire && (wrAddr == ADDR_CONTROL) && (ctrlOp == OP_RETURN);
  assign doIrq = wrFire && (wrAddr == ADDR_CONTROL) && (ctrlOp == OP_IRQ);
  assign doStep = wrFire && (wrAddr == ADDR_CONTROL) && (ctrlOp == OP_STEP);

  // Low-byte write takes its page from the latch; the step add carries on into the upper bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_reg <= PC_RESET;
    end else if (wrPcLow) begin
      pc_reg <= {pc_high_latch_reg[4:0], wrData[7:0]};
    end else if (doCall || doJump) begin
      pc_reg <= {pc_high_latch_reg[4:LATCH_JUMP_LSB], ctrlArg[TARGET_LSB +: TARGET_WIDTH]};
    end else if (doRet) begin
      pc_reg <= stackTop;
    end else if (doIrq) begin
      pc_reg <= INT_VECTOR;
    end else if (doStep) begin
      pc_reg <= pc_reg + 13'h0001;
    end
  end

  // Return address is the instruction after the call
  pcsa_return_stack #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(PC_WIDTH)
  ) u_stack (
    .clk(clk),
    .rst(rst),
    .push(doCall || doIrq),
    .pop(doRet),
    .pushData(doIrq ? pc_reg : pc_reg + 13'h0001),
    .topData(stackTop)
  );

  // ----------------------------------------
  // Latch, pointer and status registers
  // ----------------------------------------
  // Only an explicit write changes the latch, never the stack
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_high_latch_reg <= LATCH_RESET;
    end else if (wrFire && (wrAddr == ADDR_HIGH_LATCH) && wrStrb[0]) begin
      pc_high_latch_reg <= {3'h0, wrData[4:0]};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      file_select_pointer_reg <= POINTER_RESET;
    end else if (wrFire && (wrAddr == ADDR_POINTER) && wrStrb[0]) begin
      file_select_pointer_reg <= wrData[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_reg <= STATUS_RESET;
    end else if (wrFire && (wrAddr == ADDR_STATUS) && wrStrb[0]) begin
      status_reg <= wrData[7:0];
    end
  end

  // ----------------------------------------
  // Data addressing
  // ----------------------------------------
  pcsa_ind_addr u_ind (
    .indBank(status_reg[STATUS_IND_BANK_BIT]),
    .pointer(file_select_pointer_reg),
    .fileAddr(fileAddr),
    .dirBank(status_reg[STATUS_DIR_BANK_BIT]),
    .effAddr(effAddr),
    .selfRef(selfRef)
  );

  // Self-reference suppresses the store but not flag updates elsewhere
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dataAddr <= '0;
      dataWriteEn <= 1'b0;
      dataReadZero <= 1'b0;
    end else begin
      dataAddr <= effAddr;
      dataWriteEn <= fileWrite && !selfRef;
      dataReadZero <= selfRef;
    end
  end

  assign progAddr = pc_reg;

  // ----------------------------------------
  // Read path and responses
  // ----------------------------------------
  logic [31:0] rdMux;
  logic [1:0] rdResp;

  always_comb begin
    rdMux = 32'h00000000;
    rdResp = RESP_OKAY;
    case (s_axi_araddr)
      ADDR_PC_LOW: rdMux = {24'h000000, pc_reg[7:0]};
      ADDR_HIGH_LATCH: rdMux = {24'h000000, pc_high_latch_reg};
      ADDR_POINTER: rdMux = {24'h000000, file_select_pointer_reg};
      ADDR_STATUS: rdMux = {24'h000000, status_reg};
      ADDR_CONTROL: rdMux = 32'h00000000;
      ADDR_PC_FULL: rdMux = {19'h00000, pc_reg};
      ADDR_IND_DATA: rdMux = 32'h00000000;
      ADDR_IND_ADDR: rdMux = {23'h000000, effAddr};
      default: rdResp = RESP_SLVERR;
    endcase
  end

  // Single outstanding transaction in all, read or write; read waits on write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_reg <= ST_IDLE;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
      bresp_reg <= RESP_OKAY;
    end else begin
      case (bus_reg)
        ST_IDLE: begin
          if (wrFire) begin
            bresp_reg <= wrOk ? RESP_OKAY : RESP_SLVERR;
            bus_reg <= ST_WRESP;
          end else if (s_axi_arvalid) begin
            rdata_reg <= rdMux;
            rresp_reg <= rdResp;
            bus_reg <= ST_RRESP;
          end
        end
        ST_WRESP: begin
          if (s_axi_bready) begin
            bus_reg <= ST_IDLE;
          end
        end
        ST_RRESP: begin
          if (s_axi_rready) begin
            bus_reg <= ST_IDLE;
          end
        end
        default: bus_reg <= ST_IDLE;
      endcase
    end
  end

  assign s_axi_arready = (bus_reg == ST_IDLE) && !wrFire;
  assign s_axi_bvalid = (bus_reg == ST_WRESP);
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = (bus_reg == ST_RRESP);
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
endmodule

// [common/pcsa_pkg.sv]
package pcsa_pkg;
  // ----------------------------------------
  // Program counter and stack geometry
  // ----------------------------------------
  localparam int PC_WIDTH = 13;
  localparam int STACK_DEPTH = 8;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam int TARGET_LSB = 0;
  localparam int TARGET_WIDTH = 11;
  localparam int LATCH_JUMP_LSB = 3;
  localparam logic [12:0] INT_VECTOR = 13'h0004;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_PC_LOW = 8'h00;
  localparam logic [7:0] ADDR_HIGH_LATCH = 8'h04;
  localparam logic [7:0] ADDR_POINTER = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_CONTROL = 8'h10;
  localparam logic [7:0] ADDR_PC_FULL = 8'h14;
  localparam logic [7:0] ADDR_IND_DATA = 8'h18;
  localparam logic [7:0] ADDR_IND_ADDR = 8'h1c;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int STATUS_IND_BANK_BIT = 7;
  localparam int STATUS_DIR_BANK_BIT = 5;
  localparam int CTRL_OP_LSB = 16;
  localparam int CTRL_OP_WIDTH = 3;
  localparam int CTRL_ARG_WIDTH = 13;
  localparam logic [7:0] STATUS_RESET = 8'h18;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] POINTER_RESET = 8'h00;
  localparam logic [7:0] IND_SELF_ADDR = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Control operation codes
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_STEP = 3'h1;
  localparam logic [2:0] OP_JUMP = 3'h2;
  localparam logic [2:0] OP_CALL = 3'h3;
  localparam logic [2:0] OP_RETURN = 3'h4;
  localparam logic [2:0] OP_IRQ = 3'h5;

  // Bus slave states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WRESP = 3'b010,
    ST_RRESP = 3'b100
  } pcsa_bus_e;
endpackage

// [rtl/pcsa_return_stack.sv]
`timescale 1ns/100ps
module pcsa_return_stack
  import pcsa_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH,
  parameter int WIDTH = PC_WIDTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic push,
  input wire logic pop,
  input wire logic [WIDTH-1:0] pushData,
  output logic [WIDTH-1:0] topData
);
  localparam int PW = $clog2(DEPTH);

  // ----------------------------------------
  // Circular storage, pointer hidden
  // ----------------------------------------
  logic [WIDTH-1:0] entry [DEPTH];
  logic [PW-1:0] ptr_reg;

  // Pointer wraps silently; no overflow or underflow flag exists
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr_reg <= '0;
    end else if (push) begin
      ptr_reg <= ptr_reg + 1'b1;
    end else if (pop) begin
      ptr_reg <= ptr_reg - 1'b1;
    end
  end

  // Ninth push lands on the first entry again
  always_ff @(posedge clk) begin
    if (push) begin
      entry[ptr_reg] <= pushData;
    end
  end

  // Top of stack is the last pushed entry
  assign topData = entry[ptr_reg - 1'b1];
endmodule

// [rtl/pcsa_ind_addr.sv]
`timescale 1ns/100ps
module pcsa_ind_addr
  import pcsa_pkg::*;
(
  input wire logic indBank,
  input wire logic [7:0] pointer,
  input wire logic [7:0] fileAddr,
  input wire logic dirBank,
  output logic [8:0] effAddr,
  output logic selfRef
);
  // ----------------------------------------
  // Direct or indirect address forming
  // ----------------------------------------
  // Address zero is the indirect port; it has no storage of its own
  always_comb begin
    if (fileAddr == IND_SELF_ADDR) begin
      effAddr = {indBank, pointer};
    end else begin
      effAddr = {dirBank, fileAddr[6:0]};
    end
    selfRef = (fileAddr == IND_SELF_ADDR) && (pointer[6:0] == IND_SELF_ADDR[6:0]);
  end
endmodule

// [bench/pcsa_core_checker.sv]
`timescale 1ns/100ps
module pcsa_core_checker
  import pcsa_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] fileAddr,
  input wire logic fileWrite,
  input wire logic [12:0] progAddr,
  input wire logic [8:0] dataAddr,
  input wire logic dataWriteEn,
  input wire logic dataReadZero
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ----
  // Bus answers
  // ----
  logic wrFire;
  assign wrFire = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  property p_wrAnswer; wrFire |=> s_axi_bvalid; endproperty
  a_wrAnswer: assert property (p_wrAnswer) else $error("write not answered");
  property p_rdAnswer; s_axi_arvalid && s_axi_arready && !wrFire |=> s_axi_rvalid; endproperty
  a_rdAnswer: assert property (p_rdAnswer) else $error("read not answered");
  property p_rdHold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rdHold: assert property (p_rdHold) else $error("read data dropped");
  // ----
  // Program counter
  // ----
  // Reset must win even mid-run, so this one is not disabled by it
  property p_pcReset; disable iff (1'h0) rst |-> progAddr == PC_RESET; endproperty
  a_pcReset: assert property (p_pcReset) else $error("pc not cleared");
  property p_pcStable; !wrFire ##1 !wrFire |=> $stable(progAddr); endproperty
  a_pcStable: assert property (p_pcStable) else $error("pc moved without access");
  // ----
  // Data addressing
  // ----
  property p_weCause; dataWriteEn |-> $past(fileWrite); endproperty
  a_weCause: assert property (p_weCause) else $error("store without write");
  property p_zeroNoWrite; dataReadZero |-> !dataWriteEn; endproperty
  a_zeroNoWrite: assert property (p_zeroNoWrite) else $error("self store allowed");
  property p_zeroCause; dataReadZero |-> $past(fileAddr) == 8'h00; endproperty
  a_zeroCause: assert property (p_zeroCause) else $error("zero read off port");
  property p_directAddr; fileAddr != 8'h00 |=> dataAddr[6:0] == $past(fileAddr[6:0]); endproperty
  a_directAddr: assert property (p_directAddr) else $error("direct address wrong");
endmodule

bind pcsa_core pcsa_core_checker chk_u (
  .clk(clk),
  .rst(rst),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .fileAddr(fileAddr),
  .fileWrite(fileWrite),
  .progAddr(progAddr),
  .dataAddr(dataAddr),
  .dataWriteEn(dataWriteEn),
  .dataReadZero(dataReadZero)
);

// [bench/pcsa_data_file.sv]
`timescale 1ns/100ps
module pcsa_data_file
  import pcsa_pkg::*;
(
  input wire logic clk,
  input wire logic [8:0] dataAddr,
  input wire logic dataWriteEn,
  output logic [8:0] lastWriteAddr
);
  // Only stores that were allowed land here; refused ones leave no trace
  always @(posedge clk) begin
    if (dataWriteEn) begin
      lastWriteAddr <= dataAddr;
    end
  end
endmodule

// [bench/pcsa_core_tb.sv]
`timescale 1ns/100ps
module pcsa_core_tb
  import pcsa_pkg::*;
;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, fileAddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, fileWrite = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic dataWriteEn, dataReadZero;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [12:0] progAddr;
  logic [8:0] dataAddr, lastWriteAddr;
  int n_mismatch = 0;
  int n_compared = 0;

  pcsa_core dut_u (
    .clk(clk),
    .rst(rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .fileAddr(fileAddr),
    .fileWrite(fileWrite),
    .progAddr(progAddr),
    .dataAddr(dataAddr),
    .dataWriteEn(dataWriteEn),
    .dataReadZero(dataReadZero)
  );
  pcsa_data_file mem_u (.clk(clk), .dataAddr(dataAddr), .dataWriteEn(dataWriteEn), .lastWriteAddr(lastWriteAddr));

  initial begin
    forever #4 clk = ~clk;
  end
  // ----
  // Access tasks
  // ----
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Both channels offered together; each dropped as soon as it is taken
  task automatic busWrite(input logic [7:0] addr, input logic [31:0] data, input logic [1:0] resp);
    logic awDone, wDone;
    awDone = 1'h0;
    wDone = 1'h0;
    @(posedge clk);
    s_axi_awaddr <= addr;
    s_axi_wdata <= data;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(awDone && wDone)) begin
      @(posedge clk);
      if (s_axi_awready === 1'h1) awDone = 1'h1;
      if (s_axi_wready === 1'h1) wDone = 1'h1;
      if (awDone) s_axi_awvalid <= 1'h0;
      if (wDone) s_axi_wvalid <= 1'h0;
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    check({30'h0, s_axi_bresp}, {30'h0, resp}, "write response");
  endtask

  // Ready held from the request on; data taken at the edge where valid is seen
  task automatic busRead(input logic [7:0] addr, input logic [31:0] exp, input logic [1:0] resp, input string what);
    @(posedge clk);
    s_axi_araddr <= addr;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge clk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk); while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    check({30'h0, s_axi_rresp}, {30'h0, resp}, "read response");
    if (resp === RESP_OKAY) check(s_axi_rdata, exp, what);
  endtask

  task automatic op(input logic [2:0] code, input logic [10:0] tgt);
    busWrite(ADDR_CONTROL, {13'h0, code, 5'h0, tgt}, RESP_OKAY);
  endtask

  task automatic pcChk(input logic [12:0] exp, input string what);
    busRead(ADDR_PC_FULL, {19'h0, exp}, RESP_OKAY, what);
  endtask

  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ----
  // Tests
  // ----
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    busRead(ADDR_STATUS, 32'h18, RESP_OKAY, "status reset");
    pcChk(13'h0000, "pc reset");
    busRead(ADDR_HIGH_LATCH, 32'h0, RESP_OKAY, "latch reset");
    $display("test reset done");
    busWrite(ADDR_HIGH_LATCH, 32'h1f, RESP_OKAY);
    busWrite(ADDR_PC_LOW, 32'ha5, RESP_OKAY);
    pcChk(13'h1fa5, "low byte load");
    busRead(ADDR_PC_LOW, 32'ha5, RESP_OKAY, "low byte read");
    op(OP_JUMP, 11'h123);
    pcChk(13'h1923, "jump");
    op(OP_STEP, 11'h0);
    pcChk(13'h1924, "step");
    // Table offset crossing the page wraps in the page
    busWrite(ADDR_HIGH_LATCH, 32'h02, RESP_OKAY);
    busWrite(ADDR_PC_LOW, 32'hf0, RESP_OKAY);
    busWrite(ADDR_PC_LOW, 32'h10, RESP_OKAY);
    pcChk(13'h0210, "computed jump");
    $display("test pc load done");
    // Nine calls: the ninth overwrites the first entry
    busWrite(ADDR_HIGH_LATCH, 32'h08, RESP_OKAY);
    op(OP_JUMP, 11'h100);
    for (int k = 1; k <= 9; k++) begin
      op(OP_CALL, 11'h200 + 11'(k));
    end
    for (int k = 9; k >= 2; k--) begin
      op(OP_RETURN, 11'h0);
      pcChk(13'h0a00 + 13'(k), "pop order");
    end
    op(OP_RETURN, 11'h0);
    pcChk(13'h0a09, "silent underflow");
    busRead(ADDR_HIGH_LATCH, 32'h08, RESP_OKAY, "latch kept");
    op(OP_IRQ, 11'h0);
    pcChk(INT_VECTOR, "interrupt vector");
    op(OP_RETURN, 11'h0);
    pcChk(13'h0a09, "interrupt return");
    $display("test stack done");
    busWrite(ADDR_STATUS, 32'h98, RESP_OKAY);
    busWrite(ADDR_POINTER, 32'h35, RESP_OKAY);
    fileWrite <= 1'h1;
    repeat (2) @(posedge clk);
    check({23'h0, dataAddr}, 32'h135, "indirect address");
    check({31'h0, dataWriteEn}, 32'h1, "indirect store");
    @(posedge clk);
    check({23'h0, lastWriteAddr}, 32'h135, "stored location");
    busWrite(ADDR_POINTER, 32'h00, RESP_OKAY);
    repeat (2) @(posedge clk);
    check({31'h0, dataReadZero}, 32'h1, "self read zero");
    check({31'h0, dataWriteEn}, 32'h0, "self store blocked");
    busRead(ADDR_IND_DATA, 32'h0, RESP_OKAY, "port reads zero");
    busWrite(ADDR_STATUS, 32'h38, RESP_OKAY);
    fileAddr <= 8'h25;
    repeat (2) @(posedge clk);
    check({24'h0, dataAddr[7:0]}, 32'ha5, "direct upper bank");
    fileWrite <= 1'h0;
    $display("test addressing done");
    busWrite(8'h20, 32'h1, RESP_SLVERR);
    busRead(8'h24, 32'h0, RESP_SLVERR, "unmapped read");
    $display("test unmapped done");
    conclude();
  end

  // Whole run is under two hundred cycles; this leaves a wide margin
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    $display("wrong value at %0t: run hung", $time);
    conclude();
  end
endmodule
